//--- hdl/can_bit_timing_error_irq_regs.sv
// can bit timing, error counter and interrupt register slice, wishbone slave
// assumes the protocol engine drives events, error states and counters
// synchronously to i_clk_sys, and i_clk_sys is four times the instruction clock
`timescale 1ns/10ps

module can_bit_timing_error_irq_regs
  import can_regs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_module_clock_select,
  input wire logic i_can_rx,
  input wire logic i_sleep,
  input wire can_event_s i_events,
  input wire can_err_state_s i_err_state,
  input wire logic [7:0] i_tx_error_counter,
  input wire logic [7:0] i_rx_error_counter,
  output logic o_irq,
  output logic o_time_quantum,
  output logic o_bit_start,
  output logic o_sample_strobe,
  output logic o_sampled_bit,
  output logic o_wake_detect
);

  // ----------------------------------------------------------------
  // state and decoded fields
  // ----------------------------------------------------------------
  regs_state_s s;
  regs_state_s n;

  logic [1:0] resync_jump_width;
  logic [5:0] quantum_prescaler;
  logic wake_line_filter_en;
  logic [2:0] phase_two_length;
  logic phase_two_select;
  logic triple_sample_en;
  logic [2:0] phase_one_length;
  logic [2:0] propagation_length;
  logic [3:0] jump_quanta;
  logic [3:0] prop_len;
  logic [3:0] ph1_len;
  logic [3:0] ph1_base;
  logic [3:0] ph2_len;
  logic [15:0] flag_view;

  assign resync_jump_width = s.cfg_one[JUMP_LSB +: 2];
  assign quantum_prescaler = s.cfg_one[PRESCALE_LSB +: 6];
  assign wake_line_filter_en = s.cfg_two[WAKE_FIL_POS];
  assign phase_two_length = s.cfg_two[PH_TWO_LSB +: 3];
  assign phase_two_select = s.cfg_two[PH_TWO_SEL_POS];
  assign triple_sample_en = s.cfg_two[TRIPLE_POS];
  assign phase_one_length = s.cfg_two[PH_ONE_LSB +: 3];
  assign propagation_length = s.cfg_two[PROP_LSB +: 3];

  assign jump_quanta = {2'h0, resync_jump_width} + 4'h1;
  assign prop_len = {1'b0, propagation_length} + 4'h1;
  assign ph1_base = {1'b0, phase_one_length} + 4'h1;
  assign ph1_len = ph1_base + s.ext;
  always_comb
  begin
    if (phase_two_select)
    begin
      ph2_len = {1'b0, phase_two_length} + 4'h1;
    end
    else if (ph1_base > PROC_TIME_QUANTA)
    begin
      ph2_len = ph1_base;
    end
    else
    begin
      ph2_len = PROC_TIME_QUANTA;
    end
  end

  // flag register view, live state bits
  assign flag_view = {s.ovf[0], s.ovf[1], s.stat,
    s.stat.tx_warning_state | s.stat.rx_warning_state, s.flags};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic access;
    logic wr;
    logic [15:0] wmask;
    logic [15:0] wdat;
    logic [15:0] rval;
    logic mod_en;
    logic q_tick;
    logic rx_now;
    logic edge_seen;
    logic [4:0] step;
    logic [4:0] reach;
    logic [7:0] flag_set;
    logic err_rise;
    logic [3:0] ext_new;
    access = 1'b0;
    wr = 1'b0;
    wmask = 16'h0000;
    wdat = 16'h0000;
    rval = 16'h0000;
    mod_en = 1'b0;
    q_tick = 1'b0;
    rx_now = i_can_rx;
    edge_seen = 1'b0;
    step = 5'h01;
    reach = 5'h00;
    flag_set = 8'h00;
    err_rise = 1'b0;
    ext_new = 4'h0;
    n = s;

    // ----------------------------------------------------------------
    // wishbone slave: one request, ack in the next cycle
    // ----------------------------------------------------------------
    access = i_wb_cyc & i_wb_stb & ~s.ack;
    wr = access & i_wb_we;
    wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wdat = i_wb_dat[15:0] & wmask;
    n.ack = access;
    case (i_wb_adr)
      OFS_CFG_ONE: rval = s.cfg_one;
      OFS_CFG_TWO: rval = s.cfg_two;
      OFS_ERR_COUNT: rval = s.err_count;
      OFS_IRQ_EN: rval = {8'h00, s.irq_en};
      OFS_IRQ_FLAG: rval = flag_view;
      default: rval = 16'h0000;
    endcase
    n.rdat = (access & ~i_wb_we) ? {16'h0000, rval} : 32'h0000_0000;

    if (wr && i_wb_adr == OFS_CFG_ONE)
    begin
      n.cfg_one = ((s.cfg_one & ~wmask) | wdat) & CFG_ONE_MASK;
    end
    if (wr && i_wb_adr == OFS_CFG_TWO)
    begin
      n.cfg_two = ((s.cfg_two & ~wmask) | wdat) & CFG_TWO_MASK;
    end
    if (wr && i_wb_adr == OFS_IRQ_EN)
    begin
      n.irq_en = 8'(((s.irq_en & ~wmask[7:0]) | wdat[7:0]) & IRQ_EN_MASK[7:0]);
    end
    if (wr && i_wb_adr == OFS_IRQ_FLAG)
    begin
      n.flags = (s.flags & ~wmask[7:0]) | wdat[7:0];
      // overflow bits clear on a zero write to the upper byte lane
      if (i_wb_sel[1] && !i_wb_dat[OVF_RX0_POS])
      begin
        n.ovf[0] = 1'b0;
      end
      if (i_wb_sel[1] && !i_wb_dat[OVF_RX1_POS])
      begin
        n.ovf[1] = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // error state and counters
    // ----------------------------------------------------------------
    // counters copied from the engine
    n.err_count = {i_tx_error_counter, i_rx_error_counter};
    n.stat = i_err_state;
    err_rise = |(i_err_state & ~s.stat);

    // ----------------------------------------------------------------
    // wake-up detection
    // ----------------------------------------------------------------
    n.rx_prev = rx_now;
    if (rx_now)
    begin
      n.low_cnt = 5'h00;
    end
    else if (s.low_cnt != 5'(WAKE_FILT_CYC))
    begin
      n.low_cnt = s.low_cnt + 5'h01;
    end
    if (wake_line_filter_en)
    begin
      n.wake_hit = i_sleep & ~rx_now & (s.low_cnt == 5'(WAKE_FILT_CYC - 1));
    end
    else
    begin
      n.wake_hit = i_sleep & s.rx_prev & ~rx_now;
    end

    // ----------------------------------------------------------------
    // flags: hardware set wins over software clear
    // ----------------------------------------------------------------
    // flag sources
    flag_set = {i_events.rx_msg_error, s.wake_hit,
      err_rise | i_events.rxbuf0_ovf | i_events.rxbuf1_ovf,
      i_events.txbuf2_done, i_events.txbuf1_done, i_events.txbuf0_done,
      i_events.rxbuf1_done, i_events.rxbuf0_done};
    n.flags = n.flags | flag_set;
    n.ovf[0] = n.ovf[0] | i_events.rxbuf0_ovf;
    n.ovf[1] = n.ovf[1] | i_events.rxbuf1_ovf;
    n.irq = |(s.flags & s.irq_en);

    // ----------------------------------------------------------------
    // module clock and quantum prescaler
    // ----------------------------------------------------------------
    n.instr_div = s.instr_div + 2'h1;
    mod_en = i_module_clock_select | (s.instr_div == INSTR_DIV_LAST);
    q_tick = mod_en & (s.pre >= {quantum_prescaler, 1'b1});
    if (mod_en)
    begin
      n.pre = q_tick ? 7'h00 : s.pre + 7'h01;
    end
    n.quantum = q_tick;
    n.sampled = 1'b0;
    n.bit_start = 1'b0;

    // ----------------------------------------------------------------
    // bit segments
    // ----------------------------------------------------------------
    if (q_tick)
    begin
      edge_seen = s.rx_hist[0] & ~rx_now & ~s.resynced;
      n.rx_hist = {s.rx_hist[0], rx_now};
      n.pos = s.pos + 5'h01;
      case (s.seg)
        SEG_SYNC:
        begin
          n.seg = SEG_PROP;
          n.qcnt = 4'h0;
          n.pos = 5'h01;
          n.ext = 4'h0;
          n.resynced = 1'b0;
          n.bit_start = 1'b1;
        end
        SEG_PROP, SEG_PH1:
        begin
          // lengthen phase one by at most the jump width
          if (edge_seen)
          begin
            ext_new = (s.pos > {1'b0, jump_quanta}) ? jump_quanta : s.pos[3:0];
            n.ext = ext_new;
            n.resynced = 1'b1;
          end
          reach = {1'b0, s.qcnt} + 5'h01;
          if (s.seg == SEG_PROP)
          begin
            if (reach >= {1'b0, prop_len})
            begin
              n.seg = SEG_PH1;
              n.qcnt = 4'h0;
            end
            else
            begin
              n.qcnt = reach[3:0];
            end
          end
          else if (reach >= {1'b0, ph1_len})
          begin
            // single or majority of three samples
            if (triple_sample_en)
            begin
              n.bit_val = (s.rx_hist[1] & s.rx_hist[0]) | (s.rx_hist[1] & rx_now) |
                (s.rx_hist[0] & rx_now);
            end
            else
            begin
              n.bit_val = rx_now;
            end
            n.sampled = 1'b1;
            n.seg = SEG_PH2;
            n.qcnt = 4'h0;
          end
          else
          begin
            n.qcnt = reach[3:0];
          end
        end
        SEG_PH2:
        begin
          // shorten phase two by the jump width
          if (edge_seen)
          begin
            step = {1'b0, jump_quanta} + 5'h01;
            n.resynced = 1'b1;
          end
          reach = {1'b0, s.qcnt} + step;
          if (reach >= {1'b0, ph2_len})
          begin
            n.seg = SEG_SYNC;
            n.qcnt = 4'h0;
          end
          else
          begin
            n.qcnt = reach[3:0];
          end
        end
        default:
        begin
          n.seg = SEG_SYNC;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      s <= '0;
      s.cfg_one <= CFG_ONE_RST;
      s.cfg_two <= CFG_TWO_RST;
      s.err_count <= ERR_COUNT_RST;
      s.irq_en <= IRQ_EN_RST;
      s.flags <= IRQ_FLAG_RST;
      s.seg <= SEG_SYNC;
      s.rx_hist <= 2'h3;
      s.rx_prev <= 1'b1;
      s.bit_val <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign o_wb_ack = s.ack;
  assign o_wb_dat = s.rdat;
  assign o_irq = s.irq;
  assign o_time_quantum = s.quantum;
  assign o_bit_start = s.bit_start;
  assign o_sample_strobe = s.sampled;
  assign o_sampled_bit = s.bit_val;
  assign o_wake_detect = s.wake_hit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  logic [9:0] chk_gap;
  logic chk_steady;
  logic chk_mcs_prev;
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      chk_gap <= 10'h000;
      chk_steady <= 1'b0;
      chk_mcs_prev <= 1'b0;
    end
    else
    begin
      chk_gap <= s.quantum ? 10'h001 : chk_gap + 10'h001;
      chk_mcs_prev <= i_module_clock_select;
      if ((o_wb_ack && i_wb_we && i_wb_adr == OFS_CFG_ONE) ||
        i_module_clock_select != chk_mcs_prev)
      begin
        chk_steady <= 1'b0;
      end
      else if (s.quantum)
      begin
        chk_steady <= 1'b1;
      end
    end
  end

  sequence read_of(logic [7:0] ofs);
    i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr == ofs;
  endsequence

  chk_ack_single_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  chk_quantum_period_len: assert property (
    (s.quantum && chk_steady && $stable(i_module_clock_select) && !i_module_clock_select)
    |-> chk_gap == 10'({quantum_prescaler, 1'b1} + 7'h01) * 10'h004
    || chk_gap == 10'h000)
    else $error("quantum period wrong for slow module clock");
  chk_jump_ext_bound: assert property (s.ext <= jump_quanta)
    else $error("phase one extension beyond jump width");
  chk_ph2_auto_len: assert property (
    (!phase_two_select) |-> ph2_len >= PROC_TIME_QUANTA && ph2_len >= ph1_base)
    else $error("automatic phase two too short");
  chk_err_count_copy: assert property (
    read_of(OFS_ERR_COUNT) ##1 1'b1 |-> o_wb_dat[15:0] == $past(s.err_count))
    else $error("error counter readback mismatch");
  chk_ovf_sticky_set: assert property (
    i_events.rxbuf0_ovf |=> s.ovf[0] && s.flags[ERR_FLAG_POS])
    else $error("overflow not recorded");
  chk_warn_combined_bit: assert property (
    read_of(OFS_IRQ_FLAG) |=> o_wb_dat[8] == (o_wb_dat[10] | o_wb_dat[9]))
    else $error("combined warning bit wrong");
  chk_invalid_flag_set: assert property (i_events.rx_msg_error |=> s.flags[7])
    else $error("invalid message flag not set");
  chk_txbuf2_flag_set: assert property (i_events.txbuf2_done |=> s.flags[4])
    else $error("tx buffer 2 flag not set");
  chk_irq_follows_flag: assert property (
    (s.flags[0] && s.irq_en[0]) |=> o_irq)
    else $error("enabled flag raised no interrupt");
  chk_unimpl_read_zero: assert property (
    read_of(OFS_CFG_ONE) |=> o_wb_dat[31:8] == 24'h000000)
    else $error("unimplemented bits read nonzero");

endmodule

//--- hdl/can_regs_pkg.sv
// constants, field layouts and carrier types of the can timing/error/irq slice
// assumes a 40 MHz system clock running at four times the instruction clock
package can_regs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CFG_ONE = 8'h00;
  localparam logic [7:0] OFS_CFG_TWO = 8'h04;
  localparam logic [7:0] OFS_ERR_COUNT = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h10;

  // ----------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_ONE_MASK = 16'h00ff;
  localparam logic [15:0] CFG_TWO_MASK = 16'h47ff;
  localparam logic [15:0] IRQ_EN_MASK = 16'h00ff;
  localparam logic [15:0] CFG_ONE_RST = 16'h0000;
  localparam logic [15:0] CFG_TWO_RST = 16'h0000;
  localparam logic [15:0] ERR_COUNT_RST = 16'h0000;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] IRQ_FLAG_RST = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned JUMP_LSB = 6;
  localparam int unsigned PRESCALE_LSB = 0;
  localparam int unsigned WAKE_FIL_POS = 14;
  localparam int unsigned PH_TWO_LSB = 8;
  localparam int unsigned PH_TWO_SEL_POS = 7;
  localparam int unsigned TRIPLE_POS = 6;
  localparam int unsigned PH_ONE_LSB = 3;
  localparam int unsigned PROP_LSB = 0;
  localparam int unsigned OVF_RX0_POS = 15;
  localparam int unsigned OVF_RX1_POS = 14;
  localparam int unsigned ERR_FLAG_POS = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 40;
  localparam logic [3:0] PROC_TIME_QUANTA = 4'h3;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam int unsigned WAKE_FILT_NS = 500;
  localparam int unsigned WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // carriers and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_e;

  typedef struct packed {
    logic rx_msg_error;
    logic rxbuf0_ovf;
    logic rxbuf1_ovf;
    logic txbuf2_done;
    logic txbuf1_done;
    logic txbuf0_done;
    logic rxbuf1_done;
    logic rxbuf0_done;
  } can_event_s;

  typedef struct packed {
    logic tx_bus_off_state;
    logic tx_passive_state;
    logic rx_passive_state;
    logic tx_warning_state;
    logic rx_warning_state;
  } can_err_state_s;

  typedef struct packed {
    logic [15:0] cfg_one;
    logic [15:0] cfg_two;
    logic [15:0] err_count;
    logic [7:0] irq_en;
    logic [7:0] flags;
    logic [1:0] ovf;
    can_err_state_s stat;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic [1:0] instr_div;
    logic [6:0] pre;
    logic quantum;
    seg_e seg;
    logic [3:0] qcnt;
    logic [4:0] pos;
    logic [3:0] ext;
    logic resynced;
    logic [1:0] rx_hist;
    logic bit_val;
    logic sampled;
    logic bit_start;
    logic rx_prev;
    logic [4:0] low_cnt;
    logic wake_hit;
  } regs_state_s;

endpackage

//--- sim/can_node_model.sv
// model of another can node that shares the bus line with the block
// assumes the line idles recessive (high) through its pull-up
`timescale 1ns/10ps

module can_node_model
(
  input wire logic i_clk_sys,
  output logic o_can_rx
);
  // ------------------------------------------------------------
  // line driver
  // ------------------------------------------------------------
  initial
  begin
    o_can_rx = 1'b1;
  end

  // dominant for n cycles, then released to recessive
  task automatic send_dominant(input int n);
    o_can_rx <= 1'b0;
    repeat (n) @(posedge i_clk_sys);
    o_can_rx <= 1'b1;
  endtask
endmodule

//--- sim/tb_can_bit_timing_error_irq_regs.sv
// self-checking bench of the can timing, error and irq register slice
// assumes the package and the node model are compiled before it
`timescale 1ns/10ps

module tb_can_bit_timing_error_irq_regs
  import can_regs_pkg::*;
;
  typedef struct packed {
    logic [7:0] wa;
    logic [15:0] wd;
    logic [7:0] ra;
    logic [7:0] ev;
    logic [4:0] st;
    logic mcs;
    logic [1:0] kind;
    logic [15:0] exp;
  } row_s;

  logic clk, rst, cyc, stb, we, mcs, sleep, can_rx, ack, irq, q_pulse, bit_go, samp, wake;
  logic samp_go;
  logic [7:0] adr, tx_cnt, rx_cnt;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  can_event_s ev;
  can_err_state_s st;
  int mismatches = 0;
  int n_tests = 0;
  int wake_cnt = 0;
  int samp_cnt = 0;
  int w0;
  row_s rows[$];
  logic [15:0] ev_exp [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
                              16'h0010, 16'h4020, 16'h8020, 16'h0080};

  can_bit_timing_error_irq_regs dut_u
  (
    .i_clk_sys(clk),
    .i_reset(rst),
    .i_wb_cyc(cyc),
    .i_wb_stb(stb),
    .i_wb_we(we),
    .i_wb_adr(adr),
    .i_wb_sel(sel),
    .i_wb_dat(wdat),
    .o_wb_dat(rdat),
    .o_wb_ack(ack),
    .i_module_clock_select(mcs),
    .i_can_rx(can_rx),
    .i_sleep(sleep),
    .i_events(ev),
    .i_err_state(st),
    .i_tx_error_counter(tx_cnt),
    .i_rx_error_counter(rx_cnt),
    .o_irq(irq),
    .o_time_quantum(q_pulse),
    .o_bit_start(bit_go),
    .o_sample_strobe(samp_go),
    .o_sampled_bit(samp),
    .o_wake_detect(wake)
  );

  can_node_model node_u
  (
    .i_clk_sys(clk),
    .o_can_rx(can_rx)
  );

  // ------------------------------------------------------------
  // clock and wake and sample pulse counters
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (wake === 1'b1)
      wake_cnt++;
    if (samp_go === 1'b1)
      samp_cnt++;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      check("wishbone ack", 32'h0, 32'h1);
      report_and_stop();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, 4'h3, q);
    check(nm, q, {16'h0000, e});
  endtask

  task automatic pulse(input logic [7:0] e);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic pick(input logic b);
    return b ? bit_go : q_pulse;
  endfunction

  // cycles up to the next pulse, a lost pulse ends the run
  task automatic wait_pulse(input logic b, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pick(b) !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      check("pulse timeout", 32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  // cycles between pulses, after settling on the new setting
  task automatic gap(input logic b, input logic [15:0] e);
    int n;
    repeat (4)
      wait_pulse(b, n);
    check(b ? "bit length" : "quantum length", 32'(n), {16'h0000, e});
  endtask

  // one dominant quantum over the sample point, then the sampled level
  task automatic samp_chk(input logic [15:0] c, input logic e);
    int n;
    int s0;
    wr(OFS_CFG_TWO, c);
    wait_pulse(1'b1, n);
    s0 = samp_cnt;
    wait_pulse(1'b1, n);
    check("sample strobes", 32'(samp_cnt - s0), 32'h1);
    repeat (20) @(posedge clk);
    node_u.send_dominant(16);
    check("sampled level", 32'(samp), 32'(e));
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    mcs = 1'b1;
    sleep = 1'b0;
    ev = '0;
    st = '0;
    tx_cnt = 8'ha5;
    rx_cnt = 8'h3c;
    rows.push_back({OFS_CFG_ONE, 16'hffff, OFS_CFG_ONE, 8'h00, 5'h00, 1'b1, 2'h0, 16'h00ff});
    rows.push_back({OFS_CFG_TWO, 16'hffff, OFS_CFG_TWO, 8'h00, 5'h00, 1'b1, 2'h0, 16'h47ff});
    rows.push_back({OFS_IRQ_EN, 16'hffff, OFS_IRQ_EN, 8'h00, 5'h00, 1'b1, 2'h0, 16'h00ff});
    rows.push_back({OFS_ERR_COUNT, 16'hffff, OFS_ERR_COUNT, 8'h00, 5'h00, 1'b1, 2'h0, 16'ha53c});
    rows.push_back({8'h14, 16'hffff, 8'h14, 8'h00, 5'h00, 1'b1, 2'h0, 16'h0000});
    rows.push_back({OFS_IRQ_FLAG, 16'hffff, OFS_IRQ_FLAG, 8'h00, 5'h00, 1'b1, 2'h0, 16'h00ff});
    for (int i = 0; i < 8; i++)
      rows.push_back({8'h20, 16'h0000, OFS_IRQ_FLAG, 8'(1 << i), 5'h00, 1'b1, 2'h0, ev_exp[i]});
    for (int i = 0; i < 5; i++)
      rows.push_back({8'h20, 16'h0000, OFS_IRQ_FLAG, 8'h00, 5'(1 << i), 1'b1, 2'h0,
                      16'(32'h0200 << i) | (i < 2 ? 16'h0100 : 16'h0000) | 16'h0020});
    rows.push_back({OFS_CFG_ONE, 16'h0000, 8'h00, 8'h00, 5'h00, 1'b1, 2'h1, 16'h0002});
    rows.push_back({OFS_CFG_ONE, 16'h00ff, 8'h00, 8'h00, 5'h00, 1'b1, 2'h1, 16'h0080});
    rows.push_back({OFS_CFG_ONE, 16'h0043, 8'h00, 8'h00, 5'h00, 1'b1, 2'h1, 16'h0008});
    rows.push_back({OFS_CFG_ONE, 16'h0000, 8'h00, 8'h00, 5'h00, 1'b0, 2'h1, 16'h0008});
    rows.push_back({OFS_CFG_TWO, 16'h0001, 8'h00, 8'h00, 5'h00, 1'b1, 2'h2, 16'h000e});
    rows.push_back({OFS_CFG_TWO, 16'h0781, 8'h00, 8'h00, 5'h00, 1'b1, 2'h2, 16'h0018});
    rows.push_back({OFS_CFG_TWO, 16'h0081, 8'h00, 8'h00, 5'h00, 1'b1, 2'h2, 16'h000a});
    rows.push_back({OFS_CFG_TWO, 16'h0021, 8'h00, 8'h00, 5'h00, 1'b1, 2'h2, 16'h001a});
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[k])
    begin
      mcs <= rows[k].mcs;
      st <= rows[k].st;
      pulse(rows[k].ev);
      wr(rows[k].wa, rows[k].wd);
      if (rows[k].kind == 2'h0)
      begin
        rd_chk($sformatf("row %0d", k), rows[k].ra, rows[k].exp);
        wr(OFS_IRQ_FLAG, 16'h0000);
        st <= '0;
        @(posedge clk);
      end
      else
        gap(rows[k].kind[1], rows[k].exp);
    end
    wr(OFS_IRQ_EN, 16'h0004);
    pulse(8'h04);
    check("irq enabled", 32'(irq), 32'h1);
    wr(OFS_IRQ_EN, 16'h0003);
    repeat (3) @(posedge clk);
    check("irq masked", 32'(irq), 32'h0);
    wr(OFS_IRQ_EN, 16'h0004);
    wr(OFS_IRQ_FLAG, 16'h0000);
    repeat (3) @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    // overflow kept until cleared through the upper lane
    pulse(8'h40);
    wr(OFS_IRQ_FLAG, 16'h0000, 4'h1);
    rd_chk("ovf lane0 write", OFS_IRQ_FLAG, 16'h8000);
    wr(OFS_IRQ_FLAG, 16'hc000, 4'h2);
    rd_chk("ovf write one", OFS_IRQ_FLAG, 16'h8000);
    wr(OFS_IRQ_FLAG, 16'h0000, 4'h2);
    rd_chk("ovf write zero", OFS_IRQ_FLAG, 16'h0000);
    // wake with and without the line filter
    sleep <= 1'b1;
    wr(OFS_CFG_TWO, 16'h0000);
    w0 = wake_cnt;
    node_u.send_dominant(3);
    repeat (4) @(posedge clk);
    check("wake unfiltered", 32'(wake_cnt - w0), 32'h1);
    rd_chk("wake flag", OFS_IRQ_FLAG, 16'h0040);
    wr(OFS_IRQ_FLAG, 16'h0000);
    wr(OFS_CFG_TWO, 16'h4000);
    w0 = wake_cnt;
    node_u.send_dominant(10);
    repeat (4) @(posedge clk);
    check("wake glitch", 32'(wake_cnt - w0), 32'h0);
    node_u.send_dominant(25);
    repeat (4) @(posedge clk);
    check("wake filtered", 32'(wake_cnt - w0), 32'h1);
    rd_chk("wake flag filtered", OFS_IRQ_FLAG, 16'h0040);
    // single and triple sampling of a short dominant glitch
    sleep <= 1'b0;
    wr(OFS_CFG_ONE, 16'h0007);
    samp_chk(16'h0080, 1'b0);
    samp_chk(16'h00c0, 1'b1);
    tx_cnt <= 8'h00;
    rx_cnt <= 8'h00;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("sampled bit", 32'(samp), 32'h1);
    for (int a = 0; a < 5; a++)
      rd_chk("reset value", 8'(a * 4), 16'h0000);
    report_and_stop();
  end
endmodule
